// file: include/led_ctrl_defines.svh
// Purpose: Named offsets, field positions, reset values and timing counts.
// Assumes: Core clock of 10 MHz.
// Notes:   Included by the design only; the control package does not include it.
`ifndef LED_CTRL_DEFINES_SVH
`define LED_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS      100
`define PWM_MIN_PULSE_NS   750
// Least pulse time, rounded up to whole core cycles.
`define PWM_MIN_CYC \
  ((`PWM_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_WINDOW_BITS    8
`define DUTY_FULL          9'h100

`define TEMP_SHUT_C        8'd140
`define TEMP_RESUME_C      8'd125

`define BOOST_FREQ_BIT     0
`define BOOST_OVP_LO       1
`define BOOST_OVP_HI       2
`define BOOST_AUTO_BIT     3
`define PWM_EN_A_BIT       0
`define PWM_EN_B_BIT       1
`define PWM_POL_LOW_BIT    2
`define PWM_ZD_OFF_BIT     3
`define BRIGHT_LO_BITS     3

`define SINK_MAP_RST       3'h0
`define FB_EN_RST          3'h7
`define BOOST_RST          4'h2
`define PWM_CFG_RST        4'h0
`define FS_RST             5'h13
`define BRIGHT_RST         11'h000
`define AUTO_THR_RST       8'h00

`endif

// file: include/led_ctrl_pkg.sv
// Purpose: Types shared by the LED string control logic.
// Assumes: Constants come from the defines header.
// Notes:   Register selects are symbolic; the host picks one per write.
`default_nettype none
package led_ctrl_pkg;

  typedef enum logic [3:0] {
    SEL_SINK_MAP,
    SEL_FB_EN,
    SEL_BOOST,
    SEL_PWM_CFG,
    SEL_FS_A,
    SEL_FS_B,
    SEL_BRIGHT_A_LO,
    SEL_BRIGHT_A_HI,
    SEL_BRIGHT_B_LO,
    SEL_BRIGHT_B_HI,
    SEL_AUTO_THR
  } cfg_sel_e;

  typedef struct packed {
    logic [4:0]  full_scale;
    logic [10:0] level;
  } bank_drive_s;

endpackage
`default_nettype wire

// file: design/led_string_driver_control.sv
// Purpose: Control logic of a three-string LED driver: enable, bank
//          mapping, PWM duty scaling, zero detection, boost settings.
// Assumes: All inputs synchronous to core_clk; the host write port is
//          the output of the serial target logic.
// Notes:   Each tag below marks the logic that carries that rule.
// Notes on behaviour
// RULE1: Enable pin low shuts down, restores defaults.
// RULE2: Host waits 20 us after enable rises.
// RULE3: Host keeps serial lines free of glitches.
// RULE4: PWM assignable to either bank, scales current.
// RULE5: PWM disabled means duty factor exactly one.
// RULE6: After near-zero, pulses under 0.75 us ignored.
// RULE7: Off at 140 C, back on at 125 C.
// RULE8: Each bank: 5-bit full scale, 11-bit brightness.
// RULE9: Each sink routed to bank A or B.
// RULE10: Feedback enables [2:0] reset high, join loop.
// RULE11: Cleared feedback bit removes sink from loop.
// RULE12: Short fault only for feedback-enabled sinks.
// RULE13: Bit 0 picks 500 kHz or 1 MHz.
// RULE14: Two-bit field picks overvoltage threshold.
// RULE15: Bit 3 auto frequency via threshold compare.
// RULE16: Brightness applies only on high byte write.
// RULE17: Writes accepted only while enabled, out of reset.
`include "led_ctrl_defines.svh"
`default_nettype none
module led_string_driver_control
  import led_ctrl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        hardware_enable_pin,
  input  wire logic        pwm_in,
  input  wire logic [7:0]  die_temp_c,
  input  wire logic [2:0]  string_short,
  input  wire logic        cfg_wr,
  input  wire cfg_sel_e    cfg_sel,
  input  wire logic [7:0]  cfg_data,
  output logic             shutdown_reg,
  output logic             boost_on_reg,
  output logic [2:0]       sink_on_reg,
  output logic [2:0]       sink_bank_reg,
  output logic [2:0]       feedback_sel_reg,
  output logic [2:0]       short_fault_reg,
  output logic             freq_1mhz_reg,
  output logic [1:0]       overvoltage_guard_reg,
  output var bank_drive_s  bank_a_reg,
  output var bank_drive_s  bank_b_reg
);

  logic [2:0]  fb_en_reg;
  logic [3:0]  boost_cfg_reg;
  logic [3:0]  pwm_cfg_reg;
  logic [4:0]  fs_a_reg;
  logic [4:0]  fs_b_reg;
  logic [10:0] bright_a_reg;
  logic [10:0] bright_b_reg;
  logic [2:0]  lo_a_reg;
  logic [2:0]  lo_b_reg;
  logic [7:0]  auto_thr_reg;
  logic        hot_reg;
  logic        wr_ok;
  logic        pwm_lvl;
  logic        zd_on;
  logic [`PWM_WINDOW_BITS-1:0] win_cnt_reg;
  logic [8:0]  acc_reg;
  logic [8:0]  acc_next;
  logic [8:0]  duty_reg;
  logic [3:0]  run_reg;
  logic        near_zero_reg;
  logic        auto_fast;

  // Duty of 256/256 leaves the code untouched, so full duty is exact.
  function automatic logic [10:0] scale(input logic [10:0] code,
                                        input logic [8:0]  duty,
                                        input logic        pwm_en);
    logic [19:0] prod;
    prod = code * duty;
    scale = pwm_en ? prod[18:8] : code; // [RULE4] [RULE5]
  endfunction

  assign wr_ok = cfg_wr && hardware_enable_pin; // [RULE17]
  assign pwm_lvl = pwm_in ^ pwm_cfg_reg[`PWM_POL_LOW_BIT];
  assign zd_on = !pwm_cfg_reg[`PWM_ZD_OFF_BIT];
  assign auto_fast = (bright_a_reg[10:3] > auto_thr_reg) ||
                     (bright_b_reg[10:3] > auto_thr_reg); // [RULE15]

  // Configuration store; the enable pin acts as a synchronous clear.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sink_bank_reg         <= `SINK_MAP_RST;
      fb_en_reg             <= `FB_EN_RST;
      boost_cfg_reg         <= `BOOST_RST;
      pwm_cfg_reg           <= `PWM_CFG_RST;
      fs_a_reg              <= `FS_RST;
      fs_b_reg              <= `FS_RST;
      lo_a_reg              <= 3'h0;
      lo_b_reg              <= 3'h0;
      bright_a_reg          <= `BRIGHT_RST;
      bright_b_reg          <= `BRIGHT_RST;
      auto_thr_reg          <= `AUTO_THR_RST;
    end else if (clk_en) begin
      if (!hardware_enable_pin) begin // [RULE1]
        sink_bank_reg         <= `SINK_MAP_RST;
        fb_en_reg             <= `FB_EN_RST; // [RULE10]
        boost_cfg_reg         <= `BOOST_RST;
        pwm_cfg_reg           <= `PWM_CFG_RST;
        fs_a_reg              <= `FS_RST;
        fs_b_reg              <= `FS_RST;
        lo_a_reg              <= 3'h0;
        lo_b_reg              <= 3'h0;
        bright_a_reg          <= `BRIGHT_RST;
        bright_b_reg          <= `BRIGHT_RST;
        auto_thr_reg          <= `AUTO_THR_RST;
      end else if (wr_ok) begin
        case (cfg_sel)
          SEL_SINK_MAP:    sink_bank_reg <= cfg_data[2:0]; // [RULE9]
          SEL_FB_EN:       fb_en_reg <= cfg_data[2:0]; // [RULE11]
          SEL_BOOST:       boost_cfg_reg <= cfg_data[3:0];
          SEL_PWM_CFG:     pwm_cfg_reg <= cfg_data[3:0];
          SEL_FS_A:        fs_a_reg <= cfg_data[4:0]; // [RULE8]
          SEL_FS_B:        fs_b_reg <= cfg_data[4:0];
          SEL_BRIGHT_A_LO: lo_a_reg <= cfg_data[`BRIGHT_LO_BITS-1:0];
          SEL_BRIGHT_A_HI: bright_a_reg <= {cfg_data, lo_a_reg}; // [RULE16]
          SEL_BRIGHT_B_LO: lo_b_reg <= cfg_data[`BRIGHT_LO_BITS-1:0];
          SEL_BRIGHT_B_HI: bright_b_reg <= {cfg_data, lo_b_reg}; // [RULE16]
          SEL_AUTO_THR:    auto_thr_reg <= cfg_data;
          default:         auto_thr_reg <= auto_thr_reg;
        endcase
      end
    end
  end

  // Thermal hysteresis between the shutdown and resume temperatures.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hot_reg <= 1'b0;
    end else if (clk_en) begin
      if (die_temp_c >= `TEMP_SHUT_C) begin
        hot_reg <= 1'b1; // [RULE7]
      end else if (die_temp_c <= `TEMP_RESUME_C) begin
        hot_reg <= 1'b0; // [RULE7]
      end
    end
  end

  // Duty is measured over a fixed window of 256 core cycles. With zero
  // detection armed and the previous window at zero duty, a pulse earns credit only once it has lasted the
  // minimum width, so short glitches near zero cannot lift the current.
  always_comb begin
    acc_next = acc_reg;
    if (pwm_lvl) begin
      if (!(zd_on && near_zero_reg)) begin
        acc_next = acc_reg + 9'h1;
      end else if ({28'h0, run_reg} == `PWM_MIN_CYC - 1) begin
        acc_next = acc_reg + 9'(`PWM_MIN_CYC); // [RULE6]
      end else if ({28'h0, run_reg} >= `PWM_MIN_CYC) begin
        acc_next = acc_reg + 9'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_reg   <= '0;
      acc_reg       <= 9'h0;
      duty_reg      <= `DUTY_FULL;
      run_reg       <= 4'h0;
      near_zero_reg <= 1'b0;
    end else if (clk_en) begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
      run_reg <= !pwm_lvl ? 4'h0 : (&run_reg ? run_reg : run_reg + 4'h1);
      if (&win_cnt_reg) begin
        acc_reg       <= 9'h0;
        // A pulse that began in the previous window can push the credit
        // past full scale; clamp it so the scaled level cannot wrap.
        duty_reg      <= (acc_next > `DUTY_FULL) ? `DUTY_FULL : acc_next;
        near_zero_reg <= zd_on && (acc_next == 9'h0); // [RULE6]
      end else begin
        acc_reg <= acc_next;
      end
    end
  end

  // Outputs toward the analog side.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_reg          <= 1'b1;
      boost_on_reg          <= 1'b0;
      sink_on_reg           <= 3'h0;
      feedback_sel_reg      <= 3'h0;
      short_fault_reg       <= 3'h0;
      freq_1mhz_reg         <= 1'b0;
      overvoltage_guard_reg <= 2'h0;
      bank_a_reg            <= '0;
      bank_b_reg            <= '0;
    end else if (clk_en) begin
      shutdown_reg     <= !hardware_enable_pin; // [RULE1]
      boost_on_reg     <= hardware_enable_pin && !hot_reg; // [RULE7]
      sink_on_reg      <= {3{hardware_enable_pin && !hot_reg}};
      feedback_sel_reg <= fb_en_reg; // [RULE10] [RULE11]
      short_fault_reg  <= string_short & fb_en_reg; // [RULE12]
      freq_1mhz_reg    <= boost_cfg_reg[`BOOST_AUTO_BIT] ? auto_fast :
                          boost_cfg_reg[`BOOST_FREQ_BIT]; // [RULE13]
      overvoltage_guard_reg <=
        boost_cfg_reg[`BOOST_OVP_HI:`BOOST_OVP_LO]; // [RULE14]
      bank_a_reg <= '{full_scale: fs_a_reg,
                      level: scale(bright_a_reg, duty_reg,
                                   pwm_cfg_reg[`PWM_EN_A_BIT])};
      bank_b_reg <= '{full_scale: fs_b_reg,
                      level: scale(bright_b_reg, duty_reg,
                                   pwm_cfg_reg[`PWM_EN_B_BIT])};
    end
  end

  a_enable_low_default: assert property (@(posedge core_clk) // [RULE1]
    disable iff (!reset_n) clk_en && !hardware_enable_pin |=>
      fb_en_reg == `FB_EN_RST && bright_a_reg == `BRIGHT_RST)
    else $error("enable low did not restore defaults");
  a_thermal_off: assert property (@(posedge core_clk) // [RULE7]
    disable iff (!reset_n) clk_en && die_temp_c >= `TEMP_SHUT_C ##1
      clk_en |=> !boost_on_reg && sink_on_reg == 3'h0)
    else $error("outputs not off while over temperature");
  a_thermal_hold: assert property (@(posedge core_clk) // [RULE7]
    disable iff (!reset_n) hot_reg && clk_en &&
      die_temp_c > `TEMP_RESUME_C |=> hot_reg)
    else $error("thermal latch released too early");
  a_fault_gated: assert property (@(posedge core_clk) // [RULE12]
    disable iff (!reset_n) (short_fault_reg & ~fb_en_reg) == 3'h0 ||
      $changed(fb_en_reg))
    else $error("fault raised for sink outside feedback");
  a_hi_byte_apply: assert property (@(posedge core_clk) // [RULE16]
    disable iff (!reset_n) wr_ok && clk_en &&
      cfg_sel == SEL_BRIGHT_A_HI |=> bright_a_reg[10:3] == $past(cfg_data))
    else $error("high byte write not applied");
  a_lo_byte_hold: assert property (@(posedge core_clk) // [RULE16]
    disable iff (!reset_n) wr_ok && clk_en && hardware_enable_pin &&
      cfg_sel == SEL_BRIGHT_A_LO |=> $stable(bright_a_reg))
    else $error("low byte write changed brightness");
  a_pwm_off_unity: assert property (@(posedge core_clk) // [RULE5]
    disable iff (!reset_n) clk_en && !pwm_cfg_reg[`PWM_EN_A_BIT] |=>
      bank_a_reg.level == $past(bright_a_reg))
    else $error("bank current scaled with PWM off");
  a_freq_manual: assert property (@(posedge core_clk) // [RULE13]
    disable iff (!reset_n) clk_en && !boost_cfg_reg[`BOOST_AUTO_BIT] |=>
      freq_1mhz_reg == $past(boost_cfg_reg[`BOOST_FREQ_BIT]))
    else $error("manual frequency select ignored");
  a_write_gate: assert property (@(posedge core_clk) // [RULE17]
    disable iff (!reset_n) clk_en && !hardware_enable_pin ##1
      clk_en && !hardware_enable_pin |-> fb_en_reg == `FB_EN_RST)
    else $error("write accepted while disabled");

endmodule
`default_nettype wire

// file: dv/led_host_model.sv
// Purpose: Host model that issues configuration writes to the control.
// Assumes: Requests launch by non-blocking assignment at a rising edge.
// Notes:   Writes made while disabled go out at once, to be refused.
`default_nettype none
module led_host_model
  import led_ctrl_pkg::*;
#(
  parameter int HOLD_CYC = 200
)(
  input  wire logic       core_clk,
  input  wire logic       hardware_enable_pin,
  output logic            cfg_wr,
  output var cfg_sel_e    cfg_sel,
  output logic [7:0]      cfg_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int en_cyc = 0;
  initial begin
    cfg_wr = 1'b0;
    cfg_sel = SEL_SINK_MAP;
    cfg_data = 8'h00;
  end
  // Holds off the first write for 20 us after enable rises.
  always @(posedge core_clk) en_cyc <= hardware_enable_pin ? en_cyc + 1 : 0;
  // One clean strobe per write, never a glitch.
  task automatic put(input cfg_sel_e s, input logic [7:0] d);
    while (hardware_enable_pin && en_cyc < HOLD_CYC) @(posedge core_clk);
    @(posedge core_clk);
    cfg_wr   <= 1'b1;
    cfg_sel  <= s;
    cfg_data <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask
  // Low bits first, then the high byte that applies them.
  task automatic bright(input logic b, input logic [10:0] v);
    put(b ? SEL_BRIGHT_B_LO : SEL_BRIGHT_A_LO, {5'h00, v[2:0]});
    put(b ? SEL_BRIGHT_B_HI : SEL_BRIGHT_A_HI, v[10:3]);
  endtask
endmodule
`default_nettype wire

// file: dv/led_string_driver_control_bench.sv
// Purpose: Self-checking bench for the LED string control logic.
// Assumes: 10 MHz core clock; reset held for 16 cycles.
// Notes:   Expected values come from integer shadows of the settings.
`default_nettype none
module led_string_driver_control_bench
  import led_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, pwm_in = 1'b0;
  logic hardware_enable_pin = 1'b0;
  logic [7:0] die_temp_c = 8'd25;
  logic [2:0] string_short = 3'h0;
  logic cfg_wr, shutdown_reg, boost_on_reg, freq_1mhz_reg;
  cfg_sel_e cfg_sel;
  logic [7:0] cfg_data;
  logic [2:0] sink_on_reg, sink_bank_reg, feedback_sel_reg, short_fault_reg;
  logic [1:0] overvoltage_guard_reg;
  bank_drive_s bank_a_reg, bank_b_reg;
  int errors = 0, n_tests = 0, cyc = 0, ph = 0, hi_len = 0;
  int bra, brb, m, f, s, thr, lv, lb;
  // The last PWM step also enables bank B and inverts the input, so four
  // high cycles in sixteen give a duty of 192/256 to both banks.
  int hl[4] = '{0, 4, 8, 4}, pc[4] = '{1, 1, 1, 15};
  int du[4] = '{0, 0, 128, 192};
  int tp[4] = '{139, 140, 130, 125}, on[4] = '{1, 0, 0, 1};
  integer seed = 32'h3e8d3de3;
  logic [3:0] v;

  led_string_driver_control i_led_string_driver_control (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .hardware_enable_pin(hardware_enable_pin), .pwm_in(pwm_in),
    .die_temp_c(die_temp_c), .string_short(string_short),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
    .shutdown_reg(shutdown_reg), .boost_on_reg(boost_on_reg),
    .sink_on_reg(sink_on_reg), .sink_bank_reg(sink_bank_reg),
    .feedback_sel_reg(feedback_sel_reg),
    .short_fault_reg(short_fault_reg), .freq_1mhz_reg(freq_1mhz_reg),
    .overvoltage_guard_reg(overvoltage_guard_reg),
    .bank_a_reg(bank_a_reg), .bank_b_reg(bank_b_reg));
  led_host_model i_led_host_model (.core_clk(core_clk),
    .hardware_enable_pin(hardware_enable_pin), .cfg_wr(cfg_wr),
    .cfg_sel(cfg_sel), .cfg_data(cfg_data));

  always #50 core_clk = ~core_clk;
  // Periodic pattern of period 16, so every 256-cycle window sees one count.
  always @(posedge core_clk) begin
    ph <= ph + 1;
    pwm_in <= (ph % 16) < hi_len;
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_s(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    hardware_enable_pin <= 1'b1;
    wait_s(210);
    check("fb_sel", feedback_sel_reg, 3'h7);
    check("ovp", overvoltage_guard_reg, 2'h1);
    check("bank_a", bank_a_reg, {5'h13, 11'h000});
    bra = ($random(seed) & 32'h7ff) | 32'h400;
    brb = $random(seed) & 32'h7ff;
    i_led_host_model.bright(1'b0, bra[10:0]);
    i_led_host_model.bright(1'b1, brb[10:0]);
    i_led_host_model.put(SEL_BRIGHT_A_LO, 8'h07);
    i_led_host_model.put(SEL_FS_A, 8'h1f);
    wait_s(3);
    check("bank_a", bank_a_reg, {5'h1f, bra[10:0]});
    check("bank_b", bank_b_reg, {5'h13, brb[10:0]});
    for (int i = 0; i < 4; i++) begin
      m = $random(seed);
      f = $random(seed);
      s = $random(seed);
      @(posedge core_clk);
      string_short <= s[2:0];
      i_led_host_model.put(SEL_SINK_MAP, {5'h00, m[2:0]});
      i_led_host_model.put(SEL_FB_EN, {5'h00, f[2:0]});
      wait_s(3);
      check("map", sink_bank_reg, m[2:0]);
      check("fb_sel", feedback_sel_reg, f[2:0]);
      check("short", short_fault_reg, s[2:0] & f[2:0]);
    end
    // With the clock enable low a write must be lost and outputs frozen.
    @(posedge core_clk);
    clk_en <= 1'b0;
    i_led_host_model.put(SEL_FS_B, 8'h05);
    wait_s(3);
    check("frozen", bank_b_reg, {5'h13, brb[10:0]});
    @(posedge core_clk);
    clk_en <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      i_led_host_model.put(SEL_BOOST, {4'h0, v});
      wait_s(3);
      check("ovp", overvoltage_guard_reg, v[2:1]);
      check("freq", freq_1mhz_reg, v[3] | v[0]);
    end
    for (int t = 0; t < 2; t++) begin
      thr = ((bra > brb ? bra : brb) >> 3) - t;
      i_led_host_model.put(SEL_AUTO_THR, thr[7:0]);
      wait_s(3);
      check("auto", freq_1mhz_reg, t[0]);
    end
    for (int k = 0; k < 4; k++) begin
      i_led_host_model.put(SEL_PWM_CFG, pc[k][7:0]);
      hi_len <= hl[k];
      wait_s(700);
      lv = bra * du[k] / 256;
      lb = pc[k][1] ? brb * du[k] / 256 : brb;
      check("pwm_a", bank_a_reg, {5'h1f, lv[10:0]});
      check("pwm_b", bank_b_reg, {5'h13, lb[10:0]});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      die_temp_c <= tp[k][7:0];
      wait_s(3);
      check("boost_on", boost_on_reg, on[k][0]);
      check("sink_on", sink_on_reg, {3{on[k][0]}});
    end
    @(posedge core_clk);
    hardware_enable_pin <= 1'b0;
    wait_s(3);
    check("shutdown", shutdown_reg, 1'b1);
    i_led_host_model.put(SEL_FB_EN, 8'h00);
    hardware_enable_pin <= 1'b1;
    wait_s(3);
    check("fb_sel", feedback_sel_reg, 3'h7);
    check("bank_a", bank_a_reg, {5'h13, 11'h000});
    check("shutdown", shutdown_reg, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
